// ==== hw/cpt_count_tick.v ====
// Count tick source: internal prescaler or external event input
`timescale 1ns/10ps
`default_nettype none
`include "cpt_timer_map.vh"

module cpt_count_tick #(
  parameter DIV = `CPT_PRESCALE_DIV
) (
  input  wire core_clk,
  input  wire rst,
  input  wire run,
  input  wire src_sel,
  input  wire event_in,
  output reg  tick_q
);

  // ****************************************************************
  // Prescaler and event edge detector
  // ****************************************************************
  localparam integer CW     = (DIV > 1) ? $clog2(DIV) : 1;
  localparam integer LAST_I = DIV - 1;
  localparam [CW-1:0] LAST  = LAST_I[CW-1:0];

  reg [CW-1:0] div_q;
  reg          event_q;
  wire         fall = event_q & ~event_in;

  // Prescaler restarts when stopped so the first period is full length
  always @(posedge core_clk) begin
    if (rst) begin
      div_q   <= {CW{1'b0}};
      event_q <= 1'b1;
      tick_q  <= 1'b0;
    end else begin
      event_q <= event_in;
      if (!run || div_q == LAST) begin
        div_q <= {CW{1'b0}};
      end else begin
        div_q <= div_q + 1'b1;
      end
      if (src_sel == `CPT_SRC_EXT) begin
        tick_q <= run & fall; // Source must hold each level at least one cycle
      end else begin
        tick_q <= run & (div_q == LAST);
      end
    end
  end

endmodule

`default_nettype wire

// ==== hw/cpt_pwm_ppg.v ====
// Cascaded 16-bit PWM / PPG timer with toggle flip-flop output
`timescale 1ns/10ps
`default_nettype none
`include "cpt_timer_map.vh"

module cpt_pwm_ppg #(
  parameter DIV = `CPT_PRESCALE_DIV
) (
  input  wire        CORE_CLK,
  input  wire        RST,
  input  wire [7:0]  WDATA,
  input  wire        WR_CTRL,
  input  wire        WR_DUTY_LO,
  input  wire        WR_DUTY_HI,
  input  wire        WR_PERIOD_LO,
  input  wire        WR_PERIOD_HI,
  input  wire        SRC_SEL,
  input  wire        EVENT_IN,
  output reg  [15:0] DUTY_RD,
  output reg  [15:0] PERIOD_RD,
  output reg  [15:0] COUNT,
  output reg         RUN,
  output reg         PPG_MODE,
  output reg         FLIPFLOP,
  output reg         PERIOD_IRQ,
  output reg         OUT_PIN_N
);

  // ****************************************************************
  // Internal state
  // ****************************************************************
  reg  [7:0]  duty_lo_stage_q;
  reg  [15:0] duty_hold_q;
  wire        tick;
  wire [7:0]  lower_counter_stage = COUNT[7:0];
  wire [7:0]  upper_counter_stage = COUNT[15:8];
  wire        carry = (lower_counter_stage == `CPT_STAGE_MAX);
  wire        overflow = carry & (upper_counter_stage == `CPT_STAGE_MAX);
  reg  [15:0] count_next;
  reg         period_end;
  reg         duty_hit;
  // Next values of every register, decided combinationally
  reg         run_d;
  reg         mode_d;
  reg  [15:0] count_d;
  reg         ff_d;
  reg         irq_d;
  reg  [7:0]  duty_lo_stage_d;
  reg  [15:0] duty_hold_d;
  reg  [15:0] duty_rd_d;
  reg  [15:0] period_rd_d;

  // ****************************************************************
  // Count tick source
  // ****************************************************************
  cpt_count_tick #(
    .DIV      (DIV)
  ) u_tick (
    .core_clk (CORE_CLK),
    .rst      (RST),
    .run      (RUN),
    .src_sel  (SRC_SEL),
    .event_in (EVENT_IN),
    .tick_q   (tick)
  );

  // ****************************************************************
  // Next count and compare decisions
  // ****************************************************************
  // Upper stage only moves on the lower stage carry
  always @* begin
    count_next[7:0]  = lower_counter_stage + 8'h01;
    count_next[15:8] = carry ? upper_counter_stage + 8'h01
                             : upper_counter_stage;
    if (PPG_MODE == `CPT_MODE_PPG) begin
      period_end = (count_next == PERIOD_RD);
    end else begin
      period_end = overflow;
    end
    duty_hit = (count_next == DUTY_RD) & ~period_end;
  end

  // ****************************************************************
  // Control, counter and output flip-flop: next values
  // ****************************************************************
  // Mode is locked while running so a live period never changes kind
  always @* begin
    run_d   = RUN;
    mode_d  = PPG_MODE;
    count_d = COUNT;
    ff_d    = FLIPFLOP;
    irq_d   = 1'b0;
    if (WR_CTRL) begin
      run_d = WDATA[`CPT_CTRL_RUN_BIT];
      if (!RUN) begin
        mode_d = WDATA[`CPT_CTRL_MODE_BIT];
      end
    end
    if (!RUN) begin
      // Count restarts from zero on each start
      count_d = `CPT_RST_WORD;
      if (WR_CTRL) begin
        // Preset only from a write made while already stopped
        ff_d = WDATA[`CPT_CTRL_PRESET_BIT];
      end
      // Stopped timer holds the pin, no stray pulse at wake-up
    end else if (tick) begin
      if (period_end) begin
        count_d = `CPT_RST_WORD;
        ff_d    = ~FLIPFLOP;
        irq_d   = 1'b1;
      end else begin
        count_d = count_next;
        if (duty_hit) begin
          ff_d = ~FLIPFLOP;
        end
      end
    end
  end

  // ****************************************************************
  // Control, counter, output flip-flop and pin registers
  // ****************************************************************
  // Pin loads from the same next level, so it never lags the flip-flop
  always @(posedge CORE_CLK) begin
    if (RST) begin
      RUN        <= 1'b0;
      PPG_MODE   <= `CPT_MODE_PWM;
      COUNT      <= `CPT_RST_WORD;
      FLIPFLOP   <= `CPT_RST_FF;
      OUT_PIN_N  <= `CPT_RST_PIN;
      PERIOD_IRQ <= 1'b0;
    end else begin
      RUN        <= run_d;
      PPG_MODE   <= mode_d;
      COUNT      <= count_d;
      FLIPFLOP   <= ff_d;
      OUT_PIN_N  <= ~ff_d;
      PERIOD_IRQ <= irq_d;
    end
  end

  // ****************************************************************
  // Duty and period compare registers: next values
  // ****************************************************************
  // Hold stage makes the PWM duty update glitch free at period end
  always @* begin
    duty_lo_stage_d = duty_lo_stage_q;
    duty_hold_d     = duty_hold_q;
    duty_rd_d       = DUTY_RD;
    period_rd_d     = PERIOD_RD;
    if (PPG_MODE == `CPT_MODE_PPG) begin
      // Unbuffered: each byte takes effect at once
      if (WR_DUTY_LO) begin
        duty_rd_d[7:0] = WDATA;
      end
      if (WR_DUTY_HI) begin
        duty_rd_d[15:8] = WDATA;
      end
      if (WR_PERIOD_LO) begin
        period_rd_d[7:0] = WDATA;
      end
      if (WR_PERIOD_HI) begin
        period_rd_d[15:8] = WDATA;
      end
    end else begin
      if (WR_DUTY_LO) begin
        duty_lo_stage_d = WDATA;
      end
      if (WR_DUTY_HI) begin
        duty_hold_d = {WDATA, duty_lo_stage_q};
        if (!RUN) begin
          duty_rd_d = {WDATA, duty_lo_stage_q};
        end
      end
      // Colliding write misses this transfer, lands next period
      if (RUN && tick && period_end) begin
        duty_rd_d = duty_hold_q;
      end
    end
  end

  // ****************************************************************
  // Duty and period compare registers
  // ****************************************************************
  // Period bytes written in PWM mode are dropped on purpose
  always @(posedge CORE_CLK) begin
    if (RST) begin
      duty_lo_stage_q <= `CPT_RST_BYTE;
      duty_hold_q     <= `CPT_RST_WORD;
      DUTY_RD         <= `CPT_RST_WORD;
      PERIOD_RD       <= `CPT_RST_WORD;
    end else begin
      duty_lo_stage_q <= duty_lo_stage_d;
      duty_hold_q     <= duty_hold_d;
      DUTY_RD         <= duty_rd_d;
      PERIOD_RD       <= period_rd_d;
    end
  end

endmodule

`default_nettype wire

// ==== hw/cpt_timer_map.vh ====
// Constants for the cascaded 16-bit PWM / PPG timer
`ifndef CPT_TIMER_MAP_VH
`define CPT_TIMER_MAP_VH

// ****************************************************************
// Upper stage control byte, bit positions
// ****************************************************************
`define CPT_CTRL_PRESET_BIT 7
`define CPT_CTRL_RUN_BIT    3
`define CPT_CTRL_MODE_BIT   0

// ****************************************************************
// Mode codes and source select codes
// ****************************************************************
`define CPT_MODE_PWM 1'b0
`define CPT_MODE_PPG 1'b1
`define CPT_SRC_INT  1'b0
`define CPT_SRC_EXT  1'b1

// ****************************************************************
// Reset values and stage maximum
// ****************************************************************
`define CPT_RST_BYTE  8'h00
`define CPT_RST_WORD  16'h0000
`define CPT_RST_FF    1'b0
`define CPT_RST_PIN   1'b1
`define CPT_STAGE_MAX 8'hFF

// ****************************************************************
// Timing: default internal prescale ratio in core clocks
// ****************************************************************
`define CPT_PRESCALE_DIV 8

`endif

// ==== verif/cpt_event_src.sv ====
// External event source feeding the count input
`timescale 1ns/10ps
`default_nettype none
module cpt_event_src (
  input  wire logic clk,
  input  wire logic en,
  output wire logic ev
);
  logic [1:0] ph_q = 2'h0;
  // Each level held two cycles, idle high; stop only on a whole cycle
  always @(posedge clk) begin
    ph_q <= (en || ph_q != 2'h0) ? ph_q + 2'h1 : 2'h0;
  end
  assign ev = !ph_q[1];
endmodule
`default_nettype wire

// ==== verif/cpt_pwm_ppg_bench.sv ====
// Self-checking bench for the cascaded PWM / PPG timer
`timescale 1ns/10ps
`default_nettype none
module cpt_pwm_ppg_bench;
  logic        clk = 1'b0, rst = 1'b1, src = 1'b0, en = 1'b0;
  logic [7:0]  wd = 8'h00;
  logic [4:0]  stb = 5'h00;
  wire  [15:0] duty, per, cnt;
  wire         run, ppg, ff, irq, pin_n, ev;
  int          n_fail = 0, n_compared = 0, cyc;
  logic        latch = 1'b0;
  wire         pad = latch & pin_n; // Port pad: latch gated by pin level
  // One tick per clock keeps a full 16-bit period short
  cpt_pwm_ppg #(.DIV(1)) i_dut (.CORE_CLK(clk), .RST(rst), .WDATA(wd),
    .WR_CTRL(stb[0]), .WR_DUTY_LO(stb[1]), .WR_DUTY_HI(stb[2]),
    .WR_PERIOD_LO(stb[3]), .WR_PERIOD_HI(stb[4]), .SRC_SEL(src),
    .EVENT_IN(ev), .DUTY_RD(duty), .PERIOD_RD(per), .COUNT(cnt),
    .RUN(run), .PPG_MODE(ppg), .FLIPFLOP(ff), .PERIOD_IRQ(irq),
    .OUT_PIN_N(pin_n));
  cpt_event_src i_src (.clk(clk), .en(en), .ev(ev));
  // ****
  // Access tasks
  // ****
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Strobe k: 0 ctrl, 1/2 duty lo/hi, 3/4 period lo/hi
  task automatic wr(input int k, input logic [7:0] d);
    @(posedge clk);
    stb <= 5'h01 << k;
    wd  <= d;
    @(posedge clk);
    stb <= 5'h00;
    #1;
  endtask
  task automatic wt(input logic on_irq, input logic [15:0] c);
    cyc = 0;
    do begin
      @(posedge clk);
      #1;
      cyc++;
    end while (!(on_irq ? irq === 1'b1 : cnt === c) && cyc < 70000);
    if (cyc >= 70000) begin
      n_fail++;
      wrap_up;
    end
  endtask
  task automatic wrap_up;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ****
  // Clock, watchdog and tests
  // ****
  initial forever #50 clk = ~clk;
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    wrap_up;
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    latch <= 1'b1;
    #1;
    chk("reset level", {ff, pin_n}, 16'h0001);
    chk("pad high", 16'(pad), 16'h0001);
    wr(1, 8'hD0);
    wr(2, 8'h07);
    chk("stopped duty", duty, 16'h07D0);
    wr(0, 8'h80);
    chk("preset", {ff, pin_n}, 16'h0002);
    chk("pad low", 16'(pad), 16'h0000);
    wr(0, 8'h00);
    chk("preset low", {ff, pin_n}, 16'h0001);
    wr(0, 8'h08);
    wr(1, 8'h03);
    wr(2, 8'h00);
    chk("duty held", duty, 16'h07D0);
    wt(0, 16'h07D0);
    chk("duty match", 16'(ff), 16'h0001);
    wt(1, 16'h0000);
    chk("16 bit span", 16'(cyc), 16'hF830);
    chk("new duty", duty, 16'h0003);
    wt(0, 16'h0003);
    wr(0, 8'h00);
    chk("stop keeps level", {run, ff}, 16'h0001);
    wr(0, 8'h00);
    chk("stopped low", {ff, pin_n}, 16'h0001);
    wr(0, 8'h01);
    chk("ppg mode", {ppg, run}, 16'h0002);
    wr(3, 8'h10);
    wr(4, 8'h00);
    wr(1, 8'h04);
    wr(2, 8'h00);
    chk("period now", per, 16'h0010);
    chk("ppg duty now", duty, 16'h0004);
    wr(0, 8'h09);
    wt(1, 16'h0000);
    wt(0, 16'h0004);
    chk("ppg match", 16'(ff), 16'h0001);
    wt(1, 16'h0000);
    chk("ppg period", 16'(cyc), 16'h000C);
    wr(0, 8'h01);
    @(posedge clk);
    src <= 1'b1;
    wr(0, 8'h09);
    @(posedge clk);
    en <= 1'b1;
    repeat (20) @(posedge clk);
    en <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk("event count", cnt, 16'h0005);
    wrap_up;
  end
endmodule
bind cpt_pwm_ppg cpt_pwm_ppg_properties #(.DIV(DIV)) i_chk (
  .CORE_CLK(CORE_CLK), .RST(RST), .WDATA(WDATA), .WR_CTRL(WR_CTRL),
  .WR_DUTY_HI(WR_DUTY_HI), .SRC_SEL(SRC_SEL), .DUTY_RD(DUTY_RD),
  .COUNT(COUNT), .RUN(RUN),
  .PPG_MODE(PPG_MODE), .FLIPFLOP(FLIPFLOP), .PERIOD_IRQ(PERIOD_IRQ),
  .OUT_PIN_N(OUT_PIN_N));
`default_nettype wire

// ==== verif/cpt_pwm_ppg_properties.sv ====
// Port checks for the cascaded PWM / PPG timer
`timescale 1ns/10ps
`default_nettype none
module cpt_pwm_ppg_properties #(
  parameter int DIV = 8
) (
  input wire logic        CORE_CLK,
  input wire logic        RST,
  input wire logic [7:0]  WDATA,
  input wire logic        WR_CTRL,
  input wire logic        WR_DUTY_HI,
  input wire logic        SRC_SEL,
  input wire logic [15:0] DUTY_RD,
  input wire logic [15:0] COUNT,
  input wire logic        RUN,
  input wire logic        PPG_MODE,
  input wire logic        FLIPFLOP,
  input wire logic        PERIOD_IRQ,
  input wire logic        OUT_PIN_N
);
  // Longest wait between two internal ticks
  localparam int WRAP_MAX = DIV;
  // ****
  // One clock domain, so one default clock
  // ****
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  pin_inverse_a: assert property (OUT_PIN_N != FLIPFLOP)
    else $error("pin not inverted");
  run_ctrl_a: assert property (WR_CTRL |=> RUN == $past(WDATA[3]))
    else $error("run bit lost");
  preset_load_a: assert property (WR_CTRL && !RUN |=>
    FLIPFLOP == $past(WDATA[7]) && PPG_MODE == $past(WDATA[0]))
    else $error("preset lost");
  stop_hold_a: assert property (
    !RUN && !WR_CTRL |=> $stable(FLIPFLOP))
    else $error("level moved while stopped");
  stopped_clear_a: assert property (!RUN [*2] |-> COUNT == 16'h0000)
    else $error("count moved while stopped");
  irq_wrap_a: assert property (PERIOD_IRQ |->
    COUNT == 16'h0000 && FLIPFLOP != $past(FLIPFLOP))
    else $error("bad period end");
  pwm_wrap_a: assert property (
    RUN && !PPG_MODE && !SRC_SEL && COUNT == 16'hFFFF |->
    ##[1:WRAP_MAX] (PERIOD_IRQ || !RUN))
    else $error("no overflow event");
  duty_now_a: assert property (
    WR_DUTY_HI && (!RUN || PPG_MODE) |=> DUTY_RD[15:8] == $past(WDATA))
    else $error("duty not loaded");
  duty_hold_a: assert property (
    RUN && $past(RUN) && !PPG_MODE && !PERIOD_IRQ |-> $stable(DUTY_RD))
    else $error("duty moved mid period");
endmodule
`default_nettype wire
